// >>> hw/cbi_bus_if.sv
`timescale 1ns/1ps
// Function
// - Address strobe low: address bits 15..12 on data 3..0, status on 7..4.
// - Data line 4 high for read cycles, low for write cycles.
// - Data line 5 high when the first opcode byte is fetched.
// - Data line 6 high when a delay cycle starts.
// - Data line 7 high after halt; host may then enter debug mode.
// - Latched opcode, halt, delay, read flags captured as address strobe falls.
// - Run enable low suspends before the next instruction, keeping state.
// - Bus cycle enable low blocks the start of any bus cycle.
// - Bus request rises on demand, stays high until the cycle ends.
// - Address bus floats except during a bus cycle.
// - Sense A is an interrupt request when enabled, else a plain sense.
// - Each serial shift moves the extension register right via serial lines.
// - Three general flag outputs; host uses flags 0 and 1 in debug.
// - On-card read/write memory enabled only by select and memory select high.
// - On-card read-only memory enabled only by select and memory select high.
// - Addressed memories pull shared select low; pull-up keeps it high otherwise.
// - Low address strobe marks valid address and status.
// - Memory drives data during read strobe; captured on its rising edge.
// - Card holds write data valid while the write strobe is low.
// - Memory ready low before strobe end stretches the strobe.
// - Address drive enable low floats the address outputs.
// - Data bus floats except while a strobe is active.
module cbi_bus_if (
    input wire logic aclk, // Bus clock
    input wire logic aresetn, // Synchronous reset, low
    input wire logic [7:0] awaddr, // AXI write address
    input wire logic awvalid, // AXI write address valid
    output logic awready, // AXI write address ready
    input wire logic [31:0] wdata, // AXI write data
    input wire logic [3:0] wstrb, // AXI byte enables
    input wire logic wvalid, // AXI write data valid
    output logic wready, // AXI write data ready
    output logic [1:0] bresp, // AXI write response
    output logic bvalid, // AXI write response valid
    input wire logic bready, // AXI write response ready
    input wire logic [7:0] araddr, // AXI read address
    input wire logic arvalid, // AXI read address valid
    output logic arready, // AXI read address ready
    output logic [31:0] rdata, // AXI read data
    output logic [1:0] rresp, // AXI read response
    output logic rvalid, // AXI read valid
    input wire logic rready, // AXI read ready
    input wire cbi_pkg::cbi_pins_t bus_pins_in, // Card-edge inputs
    output logic address_strobe_n, // Address strobe, low
    output logic read_strobe_n, // Read strobe, low
    output logic write_strobe_n, // Write strobe, low
    output logic [7:0] data_status_bus_out, // Data bus drive value
    output logic data_status_bus_oe, // Data bus drive enable
    output logic [15:0] address_bus_lines_out, // Address drive value
    output logic address_bus_lines_oe, // Address drive enable
    output logic bus_request, // Bus request
    output cbi_pkg::cbi_flags_t latched_flags, // Latched status flags
    output logic serial_out_line, // Serial output
    output logic flag_out_0, // General flag 0
    output logic flag_out_1, // General flag 1
    output logic flag_out_2, // General flag 2
    output logic onboard_rw_enable, // On-card RAM enable
    output logic onboard_rom_enable // On-card ROM enable
);
    import cbi_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        cbi_pins_t s1;
        cbi_pins_t s2;
        cbi_pins_t s3;
        cbi_pins_t flt;
        cbi_state_t st;
        logic [3:0] cnt;
        logic [15:0] addr;
        logic [7:0] wdat;
        logic [7:0] rdat;
        cbi_flags_t req;
        cbi_flags_t lat;
        logic ie;
        logic [2:0] flags;
        logic [7:0] ext;
        logic sout;
        logic ads_n;
        logic rds_n;
        logic wds_n;
        logic [7:0] dout;
        logic doe;
        logic aoe;
        logic breq;
        logic ram_en;
        logic rom_en;
        logic awr;
        logic wr;
        logic bv;
        logic [1:0] bresp;
        logic arr;
        logic rv;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic awh;
        logic wh;
        logic [7:0] awa;
        logic [31:0] wd;
        logic [3:0] ws;
    } cbi_reg_t;

    localparam int ADDR_CY = ADDR_CYCLES;

    cbi_reg_t r;
    cbi_reg_t n;
    logic [7:0] ram [0:255];
    logic [7:0] ram_q;
    logic [7:0] rd_src;
    logic [31:0] wv;
    logic ram_we;
    logic do_shift;
    logic busy;

    function automatic cbi_pins_t settle(cbi_pins_t a, cbi_pins_t b, cbi_pins_t old);
        settle = (b & ~(a ^ b)) | (old & (a ^ b));
    endfunction

    function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return res;
    endfunction

    assign ram_q = ram[r.addr[7:0]];
    assign rd_src = r.ram_en ? ram_q : r.flt.data_status_bus_in;
    assign busy = (r.st != ST_IDLE);
    assign ram_we = (r.st == ST_DATA) && (r.cnt == 4'h0) && r.flt.memory_ready_hold
        && !r.req.read && r.ram_en;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        wv = 32'h0;
        do_shift = 1'b0;
        // Second and third stages must agree before a pin change counts
        n.s1 = bus_pins_in;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.flt = settle(r.s2, r.s3, r.flt);
        n.ram_en = r.flt.onboard_rw_select & r.flt.memory_select_n;
        n.rom_en = r.flt.onboard_rom_select & r.flt.memory_select_n;

        if (r.bv && bready) begin
            n.bv = 1'b0;
        end
        if (r.rv && rready) begin
            n.rv = 1'b0;
        end
        if (awvalid && r.awr) begin
            n.awh = 1'b1;
            n.awa = awaddr;
        end
        if (wvalid && r.wr) begin
            n.wh = 1'b1;
            n.wd = wdata;
            n.ws = wstrb;
        end
        if (n.awh && n.wh && !n.bv) begin
            n.awh = 1'b0;
            n.wh = 1'b0;
            n.bv = 1'b1;
            n.bresp = RESP_OKAY;
            case ({n.awa[7:2], 2'b00})
                OFF_CYCLE_ADDR: begin
                    // Address frozen while a cycle runs so the bus stays stable
                    wv = merge({16'h0, r.addr}, n.wd, n.ws);
                    if (!busy) begin
                        n.addr = wv[15:0];
                    end
                end
                OFF_CYCLE_DATA: begin
                    wv = merge({24'h0, r.wdat}, n.wd, n.ws);
                    if (!busy) begin
                        n.wdat = wv[7:0];
                    end
                end
                OFF_CYCLE_CMD: begin
                    if (!busy && n.ws[0]) begin
                        n.req = cbi_flags_t'(n.wd[3:0]);
                        n.st = ST_REQ;
                        n.breq = 1'b1;
                    end
                end
                OFF_CONTROL: begin
                    if (n.ws[0]) begin
                        n.ie = n.wd[CTL_IE_BIT];
                        n.flags = n.wd[CTL_FLAG_LSB +: 3];
                    end
                end
                OFF_SERIAL: begin
                    do_shift = 1'b1;
                    n.ext = {r.flt.serial_in_line, r.ext[7:1]};
                    n.sout = r.ext[0];
                end
                OFF_STATUS: ;
                default: n.bresp = RESP_SLVERR;
            endcase
        end

        if (arvalid && r.arr) begin
            n.rv = 1'b1;
            n.rresp = RESP_OKAY;
            n.rdata = 32'h0;
            case ({araddr[7:2], 2'b00})
                OFF_CYCLE_ADDR: n.rdata[15:0] = r.addr;
                OFF_CYCLE_DATA: n.rdata[7:0] = r.wdat;
                OFF_CYCLE_CMD: n.rdata[3:0] = r.req;
                OFF_STATUS: begin
                    n.rdata[ST_BUSY_BIT] = busy;
                    n.rdata[ST_WAIT_BIT] = (r.st == ST_REQ);
                    n.rdata[ST_SENSE_A_BIT] = r.flt.sense_a_irq & ~r.ie;
                    n.rdata[ST_IRQ_BIT] = r.flt.sense_a_irq & r.ie;
                    n.rdata[ST_SENSE_B_BIT] = r.flt.sense_b_line;
                    n.rdata[ST_RUN_BIT] = r.flt.run_enable;
                    n.rdata[ST_CYC_EN_BIT] = r.flt.bus_cycle_enable;
                    n.rdata[ST_RDATA_LSB +: 8] = r.rdat;
                end
                OFF_CONTROL: begin
                    n.rdata[CTL_IE_BIT] = r.ie;
                    n.rdata[CTL_FLAG_LSB +: 3] = r.flags;
                end
                OFF_SERIAL: begin
                    n.rdata[7:0] = r.ext;
                    n.rdata[SER_OUT_BIT] = r.sout;
                end
                default: n.rresp = RESP_SLVERR;
            endcase
        end
        n.awr = !n.awh && !n.bv;
        n.wr = !n.wh && !n.bv;
        n.arr = !n.rv;

        // --------------------------------------------------------
        // Bus cycle sequencer
        // --------------------------------------------------------
        unique case (r.st)
            ST_IDLE: begin
            end
            ST_REQ: begin
                // A new instruction waits for run; started instructions finish
                if (r.flt.bus_cycle_enable
                    && (r.flt.run_enable || !r.req.opcode_fetch_flag)) begin
                    n.st = ST_ADDR;
                    n.cnt = 4'(ADDR_CYCLES - 1);
                    n.ads_n = 1'b0;
                    n.lat = r.req;
                    n.dout = {r.req, r.addr[15:12]};
                    n.doe = 1'b1;
                    n.aoe = r.flt.address_drive_enable;
                end
            end
            ST_ADDR: begin
                n.aoe = r.flt.address_drive_enable;
                if (r.cnt != 4'h0) begin
                    n.cnt = r.cnt - 4'h1;
                end else begin
                    n.st = ST_DATA;
                    n.cnt = 4'(DATA_CYCLES - 1);
                    n.ads_n = 1'b1;
                    if (r.req.read) begin
                        n.rds_n = 1'b0;
                        n.dout = ram_q;
                        n.doe = r.ram_en;
                    end else begin
                        n.wds_n = 1'b0;
                        n.dout = r.wdat;
                        n.doe = 1'b1;
                    end
                end
            end
            ST_DATA: begin
                n.aoe = r.flt.address_drive_enable;
                if (r.cnt != 4'h0) begin
                    n.cnt = r.cnt - 4'h1;
                end else if (r.flt.memory_ready_hold) begin
                    n.st = ST_IDLE;
                    n.rds_n = 1'b1;
                    n.wds_n = 1'b1;
                    n.doe = 1'b0;
                    n.aoe = 1'b0;
                    n.breq = 1'b0;
                    if (r.req.read) begin
                        n.rdat = rd_src;
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.st <= ST_IDLE;
            r.ads_n <= 1'b1;
            r.rds_n <= 1'b1;
            r.wds_n <= 1'b1;
            r.ext <= EXT_RESET;
            r.flags <= FLAGS_RESET;
        end else begin
            r <= n;
        end
    end

    // On-card RAM has no reset; contents are undefined until written
    always_ff @(posedge aclk) begin
        if (ram_we) begin
            ram[r.addr[7:0]] <= r.wdat;
        end
    end

    assign awready = r.awr;
    assign wready = r.wr;
    assign bresp = r.bresp;
    assign bvalid = r.bv;
    assign arready = r.arr;
    assign rdata = r.rdata;
    assign rresp = r.rresp;
    assign rvalid = r.rv;
    assign address_strobe_n = r.ads_n;
    assign read_strobe_n = r.rds_n;
    assign write_strobe_n = r.wds_n;
    assign data_status_bus_out = r.dout;
    assign data_status_bus_oe = r.doe;
    assign address_bus_lines_out = r.addr;
    assign address_bus_lines_oe = r.aoe;
    assign bus_request = r.breq;
    assign latched_flags = r.lat;
    assign serial_out_line = r.sout;
    assign flag_out_0 = r.flags[0];
    assign flag_out_1 = r.flags[1];
    assign flag_out_2 = r.flags[2];
    assign onboard_rw_enable = r.ram_en;
    assign onboard_rom_enable = r.rom_en;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_status_nibble;
        !address_strobe_n |-> data_status_bus_oe
            && data_status_bus_out[3:0] == address_bus_lines_out[15:12]
            && data_status_bus_out[7:4] == latched_flags;
    endproperty
    a_status_nibble: assert property (p_status_nibble) else $error("status byte wrong");

    property p_read_bit;
        $fell(address_strobe_n) |-> ##ADDR_CY
            (latched_flags.read ? !read_strobe_n : !write_strobe_n);
    endproperty
    a_read_bit: assert property (p_read_bit) else $error("read bit mismatch");

    property p_flags_hold;
        address_strobe_n && $past(address_strobe_n) |-> $stable(latched_flags);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("latched flags moved");

    property p_addr_window;
        $fell(address_strobe_n) |-> (!address_strobe_n [*2]) ##1
            (address_strobe_n && (!read_strobe_n || !write_strobe_n));
    endproperty
    a_addr_window: assert property (p_addr_window) else $error("address strobe width");

    property p_start_gate;
        $fell(address_strobe_n) |-> $past(r.flt.bus_cycle_enable)
            && ($past(r.flt.run_enable) || !latched_flags.opcode_fetch_flag);
    endproperty
    a_start_gate: assert property (p_start_gate) else $error("cycle started blocked");

    property p_request_covers;
        (!address_strobe_n || !read_strobe_n || !write_strobe_n) |-> bus_request;
    endproperty
    a_request_covers: assert property (p_request_covers) else $error("request low in cycle");

    property p_addr_float;
        address_bus_lines_oe |-> (r.st == ST_ADDR || r.st == ST_DATA)
            && $past(r.flt.address_drive_enable);
    endproperty
    a_addr_float: assert property (p_addr_float) else $error("address driven");

    property p_data_float;
        data_status_bus_oe |-> !address_strobe_n || !read_strobe_n || !write_strobe_n;
    endproperty
    a_data_float: assert property (p_data_float) else $error("data driven idle");

    property p_stretch;
        (r.st == ST_DATA && r.cnt == 4'h0 && !r.flt.memory_ready_hold)
            |=> (!read_strobe_n || !write_strobe_n);
    endproperty
    a_stretch: assert property (p_stretch) else $error("strobe not stretched");

    property p_read_capture;
        $rose(read_strobe_n) |-> r.rdat == $past(rd_src);
    endproperty
    a_read_capture: assert property (p_read_capture) else $error("read data lost");

    property p_write_data;
        !write_strobe_n |-> data_status_bus_oe && data_status_bus_out == r.wdat;
    endproperty
    a_write_data: assert property (p_write_data) else $error("write data invalid");

    property p_serial;
        do_shift |=> r.ext == {$past(r.flt.serial_in_line), $past(r.ext[7:1])}
            && serial_out_line == $past(r.ext[0]);
    endproperty
    a_serial: assert property (p_serial) else $error("serial shift wrong");

    property p_ram_sel;
        onboard_rw_enable |-> $past(r.flt.onboard_rw_select) && $past(r.flt.memory_select_n);
    endproperty
    a_ram_sel: assert property (p_ram_sel) else $error("ram enabled wrongly");

    property p_rom_sel;
        onboard_rom_enable |-> $past(r.flt.onboard_rom_select) && $past(r.flt.memory_select_n);
    endproperty
    a_rom_sel: assert property (p_rom_sel) else $error("rom enabled wrongly");
endmodule

// >>> inc/cbi_pkg.sv
package cbi_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int ADDR_STROBE_NS = 16;
    localparam int DATA_STROBE_NS = 40;
    localparam int ADDR_CYCLES = (ADDR_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_CYCLES = (DATA_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CYCLE_ADDR = 8'h00;
    localparam logic [7:0] OFF_CYCLE_DATA = 8'h04;
    localparam logic [7:0] OFF_CYCLE_CMD = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_CONTROL = 8'h10;
    localparam logic [7:0] OFF_SERIAL = 8'h14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_WAIT_BIT = 1;
    localparam int ST_SENSE_A_BIT = 2;
    localparam int ST_SENSE_B_BIT = 3;
    localparam int ST_IRQ_BIT = 4;
    localparam int ST_RUN_BIT = 5;
    localparam int ST_CYC_EN_BIT = 6;
    localparam int ST_RDATA_LSB = 8;
    localparam int CTL_IE_BIT = 0;
    localparam int CTL_FLAG_LSB = 1;
    localparam int SER_OUT_BIT = 8;
    localparam logic [7:0] EXT_RESET = 8'h00;
    localparam logic [2:0] FLAGS_RESET = 3'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ = 2'b01,
        ST_ADDR = 2'b10,
        ST_DATA = 2'b11
    } cbi_state_t;

    // Same order as the status nibble on data lines 7..4
    typedef struct packed {
        logic halt;
        logic delay;
        logic opcode_fetch_flag;
        logic read;
    } cbi_flags_t;

    typedef struct packed {
        logic [7:0] data_status_bus_in;
        logic memory_ready_hold;
        logic run_enable;
        logic bus_cycle_enable;
        logic address_drive_enable;
        logic sense_a_irq;
        logic sense_b_line;
        logic serial_in_line;
        logic memory_select_n;
        logic onboard_rw_select;
        logic onboard_rom_select;
    } cbi_pins_t;
endpackage

// >>> verif/cbi_mem_model.sv
`timescale 1ns/1ps
module cbi_mem_model (
    input wire logic aclk, // Bus clock
    input wire logic address_strobe_n, // Address strobe
    input wire logic read_strobe_n, // Read strobe
    input wire logic write_strobe_n, // Write strobe
    input wire logic bus_request, // Cycle in progress
    input wire logic [7:0] card_data, // Card data drive
    input wire logic card_data_oe, // Card data enable
    input wire logic [15:0] card_addr, // Card address drive
    input wire logic card_addr_oe, // Card address enable
    input wire logic card_compare_enable, // Compare enable
    input wire logic [3:0] stretch, // Ready low cycles
    output logic [7:0] data_level, // Resolved data bus
    output logic memory_select_n, // Wired-AND select
    output logic memory_ready_hold // Low stretches strobe
);
    // ------------------------------------------------------------
    // Card at 8000-FFFF, sixteen bytes folded
    // ------------------------------------------------------------
    logic [7:0] mem [16];
    logic [7:0] d_last = 8'h00;
    logic [15:0] a_last = 16'h0000;
    logic [15:0] a_level;
    logic [3:0] idx = 4'h0, scnt = 4'h0;
    logic hit = 1'b0;
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = 8'hC0 + 8'(i);
    end
    // Undriven lines drift, so never show the last value
    assign a_level = card_addr_oe ? card_addr : ~a_last;
    assign memory_select_n = !(hit && bus_request);
    assign data_level = card_data_oe ? card_data
        : (hit && !read_strobe_n) ? mem[idx] : ~d_last;
    assign memory_ready_hold = !(scnt < stretch && !(read_strobe_n && write_strobe_n));
    always @(posedge aclk) begin
        d_last <= data_level;
        a_last <= a_level;
        if (!address_strobe_n) begin
            hit <= card_compare_enable && a_level[15];
            idx <= a_level[3:0];
        end else if (!bus_request) hit <= 1'b0;
        scnt <= (read_strobe_n && write_strobe_n) ? 4'h0 : scnt + {3'h0, scnt != 4'hF};
        if (hit && !write_strobe_n) mem[idx] <= data_level;
    end
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    import cbi_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, data_status_bus_out, dlev, stat, e;
    logic [31:0] wdata = 0, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, address_strobe_n, read_strobe_n;
    logic write_strobe_n, data_status_bus_oe, address_bus_lines_oe, bus_request, serial_out_line;
    logic flag_out_0, flag_out_1, flag_out_2, onboard_rw_enable, onboard_rom_enable, msn, mrdy, so;
    logic run = 0, cen = 0, ade = 0, sa = 0, sb = 0, sin = 0, rws = 0, ros = 0, aoe_as, as_q = 1;
    logic [15:0] address_bus_lines_out, a, a_as;
    logic [3:0] stretch = 0;
    cbi_flags_t latched_flags;
    cbi_pins_t pins;
    int n_errors = 0, total_checks = 0, slen = 0, slast = 0, ascnt = 0, n0, k;
    always #4 aclk = ~aclk;
    always_comb pins = '{dlev, mrdy, run, cen, ade, sa, sb, sin, msn, rws, ros};
    wire idle = address_strobe_n && read_strobe_n && write_strobe_n;
    cbi_bus_if dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF),
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .bus_pins_in(pins), .address_strobe_n, .read_strobe_n,
        .write_strobe_n, .data_status_bus_out, .data_status_bus_oe, .address_bus_lines_out,
        .address_bus_lines_oe, .bus_request, .latched_flags, .serial_out_line, .flag_out_0,
        .flag_out_1, .flag_out_2, .onboard_rw_enable, .onboard_rom_enable);
    cbi_mem_model mdl (.aclk, .address_strobe_n, .read_strobe_n, .write_strobe_n, .bus_request,
        .card_data(data_status_bus_out), .card_data_oe(data_status_bus_oe),
        .card_addr(address_bus_lines_out), .card_addr_oe(address_bus_lines_oe),
        .card_compare_enable(1'b1), .stretch, .data_level(dlev), .memory_select_n(msn),
        .memory_ready_hold(mrdy));
    // ------------------------------------------------------------
    // Bus watch and helpers
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        as_q <= address_strobe_n;
        if (!address_strobe_n) begin
            stat <= data_status_bus_out;
            aoe_as <= address_bus_lines_oe;
            a_as <= address_bus_lines_out;
        end
        if (as_q && !address_strobe_n) ascnt++;
        if (!read_strobe_n || !write_strobe_n) slen <= slen + 1;
        else if (slen != 0) begin
            slast <= slen;
            slen <= 0;
        end
        if (aresetn && !idle) chk(bus_request, 1);
        if (aresetn && !bus_request) chk(address_bus_lines_oe, 0);
        if (aresetn && idle) chk(data_status_bus_oe, 0);
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic tmo();
        n_errors++;
        $display("mismatch at %0t: wait ran out", $time);
        results();
    endtask
    task automatic axw(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] rs);
        int i;
        @(posedge aclk);
        awaddr <= ad;
        wdata <= dt;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 0;
            if (wready === 1'b1) wvalid <= 0;
            if (bvalid === 1'b1) break;
        end
        rs = bresp;
        bready <= 0;
        if (i == 100) tmo();
    endtask
    task automatic axr(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
        int i;
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1;
        rready <= 1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 0;
            if (rvalid === 1'b1) break;
        end
        dt = rdata;
        rs = rresp;
        rready <= 0;
        if (i == 100) tmo();
    endtask
    task automatic waitc();
        int i;
        for (i = 0; i < 300; i++) begin
            @(posedge aclk);
            if (bus_request === 1'b0) break;
        end
        @(posedge aclk);
        if (i == 300) tmo();
    endtask
    task automatic cyc(input logic [3:0] c);
        axw(OFF_CYCLE_CMD, {28'h0, c}, r);
        waitc();
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        run <= 1;
        cen <= 1;
        ade <= 1;
        repeat (8) @(posedge aclk);
        for (k = 0; k < 16; k++) begin
            a = {1'b1, k[2:0], 8'h00, k[3:0]};
            axw(OFF_CYCLE_ADDR, {16'h0, a}, r);
            axw(OFF_CYCLE_DATA, 32'h30 + k, r);
            cyc(k[3:0]);
            chk(stat, {k[3:0], a[15:12]});
            chk(latched_flags, k[3:0]);
            chk({aoe_as, a_as}, {1'b1, a});
            chk(slast, DATA_CYCLES);
            if (k[0]) axr(OFF_STATUS, d, r);
            if (k[0]) chk(d[15:8], 8'hC0 + k);
            else chk(mdl.mem[k], 8'h30 + k);
        end
        $display("test status and transfers done");
        stretch <= 8;
        cyc(4'h1);
        chk(slast >= 9, 1);
        stretch <= 0;
        cen <= 0;
        repeat (6) @(posedge aclk);
        n0 = ascnt;
        axw(OFF_CYCLE_CMD, 32'h0, r);
        repeat (20) @(posedge aclk);
        chk(ascnt - n0, 0);
        chk(bus_request, 1);
        cen <= 1;
        waitc();
        run <= 0;
        repeat (6) @(posedge aclk);
        cyc(4'h0);
        chk(latched_flags, 4'h0);
        n0 = ascnt;
        axw(OFF_CYCLE_CMD, 32'h3, r);
        repeat (20) @(posedge aclk);
        chk(ascnt - n0, 0);
        run <= 1;
        waitc();
        chk(latched_flags, 4'h3);
        $display("test enables done");
        rws <= 1;
        ros <= 1;
        axw(OFF_CYCLE_ADDR, 32'h12, r);
        axw(OFF_CYCLE_DATA, 32'h77, r);
        repeat (6) @(posedge aclk);
        chk({onboard_rw_enable, onboard_rom_enable}, 2'b11);
        cyc(4'h0);
        cyc(4'h1);
        axr(OFF_STATUS, d, r);
        chk(d[15:8], 8'h77);
        rws <= 0;
        ros <= 0;
        repeat (6) @(posedge aclk);
        chk({onboard_rw_enable, onboard_rom_enable}, 2'b00);
        $display("test on-card memory done");
        axw(OFF_CONTROL, 32'hB, r);
        sa <= 1;
        sb <= 1;
        repeat (6) @(posedge aclk);
        chk({flag_out_2, flag_out_1, flag_out_0}, 3'b101);
        axr(OFF_STATUS, d, r);
        chk(d[6:2], 5'b11110);
        axw(OFF_CONTROL, 32'h0, r);
        axr(OFF_STATUS, d, r);
        chk(d[6:2], 5'b11011);
        e = 8'h00;
        so = 0;
        for (k = 0; k < 10; k++) begin
            sin <= k[0] ^ k[1];
            repeat (6) @(posedge aclk);
            axw(OFF_SERIAL, 32'h0, r);
            so = e[0];
            e = {k[0] ^ k[1], e[7:1]};
        end
        axr(OFF_SERIAL, d, r);
        chk(d[8:0], {so, e});
        chk(serial_out_line, so);
        axw(8'h40, 32'h0, r);
        chk(r, RESP_SLVERR);
        axr(8'h40, d, r);
        chk({r, d}, {RESP_SLVERR, 32'h0});
        $display("test registers done");
        ade <= 0;
        repeat (6) @(posedge aclk);
        cyc(4'h0);
        chk(aoe_as, 0);
        $display("test address float done");
        results();
    end
endmodule
